/* design/ccu_capture_compare_unit.sv */
// Capture/compare unit: two time bases, 16 channels, AXI4-Lite registers
//
// Functional notes
// R1: 16 channels, 1-cycle or staggered 8-cycle resolution
// R2: Two 16-bit time bases with reload registers
// R3: Time base clock from prescaler or timer overflow
// R4: First time base can count external events
// R5: Each channel picks time base and capture/compare
// R6: Ten channels own one capture/compare pin
// R7: Mode 0: interrupt on every match
// R8: Mode 1: pin toggles on every match
// R9: Mode 2: one match interrupt per period
// R10: Mode 3: pin set on match, cleared on overflow
// R11: Double mode: two registers toggle one pin
// R12: Single-event option stops after one event (the code stops compare matches only; captures continue while set)
// R13: Capture latches time base on pin event
// R14: Each capture raises the channel interrupt
// R15: Capture edge rising, falling or both
// R16: Compare channels match continuously against time base
// R17: Overflow reloads counter from reload register
// R18: Capture pin levels held one counting step
//
// Our own choices: register access over AXI4-Lite and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module ccu_capture_compare_unit (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// AXI4-Lite slave
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Channel pins
	input wire logic [9:0] cc_pin_i,
	output logic [9:0] cc_pin_o,
	output logic [9:0] cc_pin_oe,
	// Count sources
	input wire logic ext_count_i,
	input wire logic gp_timer_ovf,
	// Interrupt
	output logic irq
);
	localparam int NCH = ccu_pkg::NCH;
	localparam int NPIN = ccu_pkg::NPIN;
	localparam int HALF = NCH / 2;

	logic [3:0] tb_ctrl_q [ccu_pkg::NTB];
	logic [15:0] tb_rel_q [ccu_pkg::NTB];
	logic [15:0] tb_val [ccu_pkg::NTB];
	logic [1:0] tb_upd;
	logic [1:0] tb_ovf;
	logic gctrl_q;
	logic [2:0] stag_cnt_q;
	logic stag_en;
	logic [6:0] ch_ctrl_q [NCH];
	logic [15:0] ch_val_q [NCH];
	ccu_pkg::ccu_mode_t ch_md [NCH];
	logic ch_tb [NCH];
	logic [NCH-1:0] once_q;
	logic [NCH-1:0] per_q;
	logic [NCH-1:0] fire;
	logic [NCH-1:0] cap;
	logic [NPIN-1:0] pin_q;
	logic [NPIN-1:0] pin_s1_q;
	logic [NPIN-1:0] pin_s2_q;
	logic [NPIN-1:0] pin_s3_q;
	logic ext_s1_q;
	logic ext_s2_q;
	logic ext_s3_q;
	logic [17:0] istat_q;
	logic [17:0] imask_q;
	logic [17:0] ev;
	logic wr_fire;
	logic rd_fire;
	logic bvalid_q;
	logic [1:0] bresp_q;
	logic rvalid_q;
	logic [1:0] rresp_q;
	logic [31:0] rdata_q;
	ccu_pkg::ccu_dec_t wdec;
	ccu_pkg::ccu_dec_t rdec;
	logic [31:0] wm;

	// ---------------------------------------------------------------
	// Decode and register read
	// ---------------------------------------------------------------
	function automatic ccu_pkg::ccu_dec_t ccu_decode(input logic [7:0] a);
		ccu_pkg::ccu_dec_t d;
		logic [7:0] o;
		d.kind = ccu_pkg::K_NONE;
		d.idx = a[5:2];
		o = a & ~ccu_pkg::TB_STRIDE;
		if (a[1:0] != 2'h0)
			d.kind = ccu_pkg::K_NONE;
		else if (a >= ccu_pkg::A_CH_VAL && a < ccu_pkg::A_CH_END)
			d.kind = ccu_pkg::K_CHVAL;
		else if (a >= ccu_pkg::A_CH_CTRL && a < ccu_pkg::A_CH_VAL)
			d.kind = ccu_pkg::K_CHCTRL;
		else if (a == ccu_pkg::A_GCTRL)
			d.kind = ccu_pkg::K_GCTRL;
		else if (a == ccu_pkg::A_ISTAT)
			d.kind = ccu_pkg::K_ISTAT;
		else if (a == ccu_pkg::A_IMASK)
			d.kind = ccu_pkg::K_IMASK;
		else if (a < ccu_pkg::A_GCTRL) begin
			d.idx = {3'h0, (a & ccu_pkg::TB_STRIDE) != 8'h00};
			if (o == ccu_pkg::A_TB_CTRL)
				d.kind = ccu_pkg::K_TBCTRL;
			else if (o == ccu_pkg::A_TB_COUNT)
				d.kind = ccu_pkg::K_TBCNT;
			else if (o == ccu_pkg::A_TB_RELOAD)
				d.kind = ccu_pkg::K_TBREL;
		end
		return d;
	endfunction

	function automatic logic [31:0] ccu_read(input ccu_pkg::ccu_dec_t d);
		logic [31:0] r;
		r = 32'h0000_0000;
		case (d.kind)
			ccu_pkg::K_TBCTRL: r = 32'(tb_ctrl_q[d.idx[0]]);
			ccu_pkg::K_TBCNT: r = 32'(tb_val[d.idx[0]]);
			ccu_pkg::K_TBREL: r = 32'(tb_rel_q[d.idx[0]]);
			ccu_pkg::K_GCTRL: r = 32'(gctrl_q);
			ccu_pkg::K_ISTAT: r = 32'(istat_q);
			ccu_pkg::K_IMASK: r = 32'(imask_q);
			ccu_pkg::K_CHCTRL: r = 32'({once_q[d.idx], ch_ctrl_q[d.idx]});
			ccu_pkg::K_CHVAL: r = 32'(ch_val_q[d.idx]);
			default: r = 32'h0000_0000;
		endcase
		return r;
	endfunction

	function automatic logic [31:0] ccu_merge(input logic [31:0] o,
		input logic [31:0] n, input logic [3:0] s);
		logic [31:0] r;
		r = o;
		for (int b = 0; b < 4; b++)
			if (s[b])
				r[b*8 +: 8] = n[b*8 +: 8];
		return r;
	endfunction

	// ---------------------------------------------------------------
	// AXI4-Lite slave
	// ---------------------------------------------------------------
	assign wdec = ccu_decode(s_axi_awaddr);
	assign rdec = ccu_decode(s_axi_araddr);
	always_comb begin
		wm = ccu_merge(ccu_read(wdec), s_axi_wdata, s_axi_wstrb);
	end
	assign wr_fire = s_axi_awvalid && s_axi_wvalid && !bvalid_q;
	assign rd_fire = s_axi_arvalid && !rvalid_q;
	assign s_axi_awready = wr_fire;
	assign s_axi_wready = wr_fire;
	assign s_axi_arready = rd_fire;
	assign s_axi_bvalid = bvalid_q;
	assign s_axi_bresp = bresp_q;
	assign s_axi_rvalid = rvalid_q;
	assign s_axi_rresp = rresp_q;
	assign s_axi_rdata = rdata_q;

	always_ff @(posedge clk) begin
		if (reset) begin
			bvalid_q <= 1'b0;
			bresp_q <= ccu_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_q <= 1'b1;
			bresp_q <= wdec.kind == ccu_pkg::K_NONE ?
				ccu_pkg::RESP_SLVERR : ccu_pkg::RESP_OKAY;
		end else if (s_axi_bready)
			bvalid_q <= 1'b0;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			rvalid_q <= 1'b0;
			rresp_q <= ccu_pkg::RESP_OKAY;
			rdata_q <= 32'h0000_0000;
		end else if (rd_fire) begin
			rvalid_q <= 1'b1;
			rdata_q <= ccu_read(rdec);
			rresp_q <= rdec.kind == ccu_pkg::K_NONE ?
				ccu_pkg::RESP_SLVERR : ccu_pkg::RESP_OKAY;
		end else if (s_axi_rready)
			rvalid_q <= 1'b0;
	end

	// ---------------------------------------------------------------
	// Configuration registers
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			gctrl_q <= 1'b0;
			imask_q <= '0;
			for (int j = 0; j < ccu_pkg::NTB; j++) begin
				tb_ctrl_q[j] <= 4'h0;
				tb_rel_q[j] <= 16'h0000;
			end
		end else if (wr_fire) begin
			if (wdec.kind == ccu_pkg::K_GCTRL)
				gctrl_q <= wm[ccu_pkg::GC_STAG];
			if (wdec.kind == ccu_pkg::K_IMASK)
				imask_q <= wm[ccu_pkg::ISTAT_W-1:0];
			if (wdec.kind == ccu_pkg::K_TBCTRL)
				tb_ctrl_q[wdec.idx[0]] <= wm[ccu_pkg::TBC_W-1:0];
			if (wdec.kind == ccu_pkg::K_TBREL)
				tb_rel_q[wdec.idx[0]] <= wm[ccu_pkg::TW-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NCH; i++)
				ch_ctrl_q[i] <= 7'h00;
		end else if (wr_fire && wdec.kind == ccu_pkg::K_CHCTRL)
			ch_ctrl_q[wdec.idx] <= wm[ccu_pkg::CHC_W-1:0]; // [R5]
	end

	// ---------------------------------------------------------------
	// Input synchronisers and stagger divider
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			pin_s1_q <= '0;
			pin_s2_q <= '0;
			pin_s3_q <= '0;
			ext_s1_q <= 1'b0;
			ext_s2_q <= 1'b0;
			ext_s3_q <= 1'b0;
		end else begin
			pin_s1_q <= cc_pin_i; // [R18]
			pin_s2_q <= pin_s1_q;
			pin_s3_q <= pin_s2_q;
			ext_s1_q <= ext_count_i;
			ext_s2_q <= ext_s1_q;
			ext_s3_q <= ext_s2_q;
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			stag_cnt_q <= 3'h0;
		else
			stag_cnt_q <= stag_cnt_q + 3'h1;
	end

	assign stag_en = !gctrl_q || stag_cnt_q == ccu_pkg::STAG_LAST; // [R1]

	// ---------------------------------------------------------------
	// Time bases
	// ---------------------------------------------------------------
	ccu_tb_if tb_if [ccu_pkg::NTB] ();

	for (genvar g = 0; g < ccu_pkg::NTB; g++) begin : g_tb
		assign tb_if[g].run = tb_ctrl_q[g][ccu_pkg::TBC_RUN];
		assign tb_if[g].sel =
			tb_ctrl_q[g][ccu_pkg::TBC_SEL_HI:ccu_pkg::TBC_SEL_LO];
		assign tb_if[g].stag_en = stag_en;
		assign tb_if[g].gp_ovf = gp_timer_ovf;
		assign tb_if[g].ext_tick = (g == 0) && ext_s2_q && !ext_s3_q; // [R4]
		assign tb_if[g].reload = tb_rel_q[g];
		assign tb_if[g].wr_cnt = wr_fire &&
			wdec.kind == ccu_pkg::K_TBCNT && wdec.idx[0] == 1'(g);
		assign tb_if[g].wr_data = wm[ccu_pkg::TW-1:0];
		assign tb_val[g] = tb_if[g].value;
		assign tb_upd[g] = tb_if[g].upd;
		assign tb_ovf[g] = tb_if[g].ovf;
		ccu_time_base u_tb ( // [R2]
			.clk(clk),
			.reset(reset),
			.bus(tb_if[g])
		);
	end

	// ---------------------------------------------------------------
	// Channel match and capture
	// ---------------------------------------------------------------
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		logic hit;
		logic hit2;
		logic lim;
		assign ch_tb[i] = ch_ctrl_q[i][ccu_pkg::CHC_TB];
		assign ch_md[i] = ccu_pkg::ccu_mode_t'(
			ch_ctrl_q[i][ccu_pkg::CHC_MODE_HI:ccu_pkg::CHC_MODE_LO]);
		assign hit = tb_upd[ch_tb[i]] && tb_val[ch_tb[i]] == ch_val_q[i];
		if (i < HALF) begin : g_pair
			assign hit2 = hit || (tb_upd[ch_tb[i]] &&
				tb_val[ch_tb[i]] == ch_val_q[i+HALF]); // [R11]
		end else begin : g_solo
			assign hit2 = hit;
		end
		assign lim = ch_md[i] == ccu_pkg::CCU_CMP2 ||
			ch_md[i] == ccu_pkg::CCU_CMP3; // [R9] [R10]
		assign fire[i] = ch_md[i] inside {ccu_pkg::CCU_CMP0,
			ccu_pkg::CCU_CMP1, ccu_pkg::CCU_CMP2, ccu_pkg::CCU_CMP3,
			ccu_pkg::CCU_DOUBLE} && !once_q[i] && !(lim && per_q[i]) &&
			(ch_md[i] == ccu_pkg::CCU_DOUBLE ? hit2 : hit); // [R16]
		if (i < NPIN) begin : g_cap
			assign cap[i] = ch_md[i] == ccu_pkg::CCU_CAPTURE && (
				(ch_ctrl_q[i][ccu_pkg::CHC_RISE] &&
				pin_s2_q[i] && !pin_s3_q[i]) ||
				(ch_ctrl_q[i][ccu_pkg::CHC_FALL] &&
				!pin_s2_q[i] && pin_s3_q[i])); // [R15]
			assign cc_pin_o[i] = pin_q[i];
			assign cc_pin_oe[i] = ch_md[i] inside {ccu_pkg::CCU_CMP1,
				ccu_pkg::CCU_CMP3, ccu_pkg::CCU_DOUBLE}; // [R6]
		end else begin : g_nocap
			assign cap[i] = 1'b0;
		end
	end

	// ---------------------------------------------------------------
	// Channel state
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset) begin
			for (int i = 0; i < NCH; i++)
				ch_val_q[i] <= 16'h0000;
		end else begin
			for (int i = 0; i < NCH; i++)
				if (cap[i])
					ch_val_q[i] <= tb_val[ch_tb[i]]; // [R13]
				else if (wr_fire && wdec.kind == ccu_pkg::K_CHVAL &&
					wdec.idx == 4'(i))
					ch_val_q[i] <= wm[ccu_pkg::TW-1:0];
		end
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			per_q <= '0;
			once_q <= '0;
		end else begin
			for (int i = 0; i < NCH; i++) begin
				if (fire[i])
					per_q[i] <= 1'b1; // [R9]
				else if (tb_ovf[ch_tb[i]] || (wr_fire &&
					wdec.kind == ccu_pkg::K_CHCTRL && wdec.idx == 4'(i)))
					per_q[i] <= 1'b0;
				if (fire[i] && ch_ctrl_q[i][ccu_pkg::CHC_ONCE])
					once_q[i] <= 1'b1; // [R12]
				else if (wr_fire && wdec.kind == ccu_pkg::K_CHCTRL &&
					wdec.idx == 4'(i))
					once_q[i] <= 1'b0;
			end
		end
	end

	always_ff @(posedge clk) begin
		if (reset)
			pin_q <= '0;
		else begin
			for (int i = 0; i < NPIN; i++)
				if (fire[i] && ch_md[i] inside {ccu_pkg::CCU_CMP1,
					ccu_pkg::CCU_DOUBLE})
					pin_q[i] <= !pin_q[i]; // [R8] [R11]
				else if (fire[i] && ch_md[i] == ccu_pkg::CCU_CMP3)
					pin_q[i] <= 1'b1; // [R10]
				else if (ch_md[i] == ccu_pkg::CCU_CMP3 && tb_ovf[ch_tb[i]])
					pin_q[i] <= 1'b0; // [R10]
		end
	end

	// ---------------------------------------------------------------
	// Interrupt status
	// ---------------------------------------------------------------
	assign ev = {tb_ovf, fire | cap}; // [R7] [R14]

	always_ff @(posedge clk) begin
		if (reset)
			istat_q <= '0;
		else if (wr_fire && wdec.kind == ccu_pkg::K_ISTAT)
			istat_q <= (istat_q & ~wm[ccu_pkg::ISTAT_W-1:0]) | ev;
		else
			istat_q <= istat_q | ev;
	end

	assign irq = |(istat_q & imask_q);

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking @(posedge clk); endclocking
	default disable iff (reset);

	property p_stag;
		$past(gctrl_q) && tb_upd[0] &&
			$past(tb_ctrl_q[0][ccu_pkg::TBC_SEL_HI]) == 1'b0
			|-> $past(stag_cnt_q) == ccu_pkg::STAG_LAST;
	endproperty
	a_stag: assert property (p_stag) // [R1]
		else $error("staggered step off the eighth cycle");

	for (genvar i = 0; i < NPIN; i++) begin : g_chk
		property p_pin;
			!cc_pin_oe[i] |=> $stable(pin_q[i]);
		endproperty
		a_pin: assert property (p_pin) // [R6]
			else $error("pin changed while not driven");
		property p_m0;
			fire[i] && ch_md[i] == ccu_pkg::CCU_CMP0 |=> istat_q[i];
		endproperty
		a_m0: assert property (p_m0) // [R7]
			else $error("mode 0 match gave no interrupt");
		property p_m1;
			fire[i] && ch_md[i] == ccu_pkg::CCU_CMP1
				|=> pin_q[i] != $past(pin_q[i]);
		endproperty
		a_m1: assert property (p_m1) // [R8]
			else $error("mode 1 pin did not toggle");
		property p_m2;
			ch_md[i] == ccu_pkg::CCU_CMP2 && per_q[i] |-> !fire[i];
		endproperty
		a_m2: assert property (p_m2) // [R9]
			else $error("second mode 2 event in one period");
		property p_m3;
			ch_md[i] == ccu_pkg::CCU_CMP3 ##1 ch_md[i] == ccu_pkg::CCU_CMP3
				&& tb_ovf[ch_tb[i]] && !fire[i] |=> !pin_q[i];
		endproperty
		a_m3: assert property (p_m3) // [R10]
			else $error("mode 3 pin not cleared on overflow");
		property p_dbl;
			fire[i] && ch_md[i] == ccu_pkg::CCU_DOUBLE
				|=> pin_q[i] != $past(pin_q[i]);
		endproperty
		a_dbl: assert property (p_dbl) // [R11]
			else $error("double mode pin did not toggle");
		property p_once;
			once_q[i] |-> !fire[i];
		endproperty
		a_once: assert property (p_once) // [R12]
			else $error("single event channel fired again");
		property p_cap;
			cap[i] |=> ch_val_q[i] == $past(tb_val[ch_tb[i]]) && istat_q[i];
		endproperty
		a_cap: assert property (p_cap) // [R13] [R14]
			else $error("capture value or interrupt missing");
	end

	c_cap: cover property (cap[2] ##1 irq);
	c_m3: cover property (pin_q[0] ##[1:50] !pin_q[0]);
	c_dbl: cover property (fire[1] && ch_md[1] == ccu_pkg::CCU_DOUBLE);
endmodule
`default_nettype wire

/* design/ccu_pkg.sv */
// Capture/compare unit package: register map, fields and encodings
package ccu_pkg;
	localparam int NCH = 16;
	localparam int NPIN = 10;
	localparam int NTB = 2;
	localparam int TW = 16;
	localparam int AW = 8;
	localparam int TBC_W = 4;
	localparam int CHC_W = 7;
	localparam int ISTAT_W = 18;
	localparam logic [2:0] STAG_LAST = 3'h7;
	localparam logic [15:0] TB_MAX = 16'hffff;
	// ---------------------------------------------------------------
	// Register offsets
	// ---------------------------------------------------------------
	localparam logic [7:0] A_TB_CTRL = 8'h00;
	localparam logic [7:0] A_TB_COUNT = 8'h04;
	localparam logic [7:0] A_TB_RELOAD = 8'h08;
	localparam logic [7:0] TB_STRIDE = 8'h10;
	localparam logic [7:0] A_GCTRL = 8'h20;
	localparam logic [7:0] A_ISTAT = 8'h24;
	localparam logic [7:0] A_IMASK = 8'h28;
	localparam logic [7:0] A_CH_CTRL = 8'h40;
	localparam logic [7:0] A_CH_VAL = 8'h80;
	localparam logic [7:0] A_CH_END = 8'hc0;
	// ---------------------------------------------------------------
	// Field positions
	// ---------------------------------------------------------------
	localparam int TBC_RUN = 0;
	localparam int TBC_SEL_LO = 1;
	localparam int TBC_SEL_HI = 3;
	localparam int CHC_TB = 0;
	localparam int CHC_MODE_LO = 1;
	localparam int CHC_MODE_HI = 3;
	localparam int CHC_RISE = 4;
	localparam int CHC_FALL = 5;
	localparam int CHC_ONCE = 6;
	localparam int CHC_DONE = 7;
	localparam int GC_STAG = 0;
	localparam int IRQ_OVF_LO = 16;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// ---------------------------------------------------------------
	// Encodings
	// ---------------------------------------------------------------
	typedef enum logic [2:0] {
		CCU_OFF, CCU_CAPTURE, CCU_CMP0, CCU_CMP1, CCU_CMP2, CCU_CMP3,
		CCU_DOUBLE
	} ccu_mode_t;
	typedef enum logic [2:0] {
		CCU_DIV1, CCU_DIV2, CCU_DIV4, CCU_DIV8, CCU_GPT, CCU_EXT
	} ccu_clksel_t;
	typedef enum logic [3:0] {
		K_NONE, K_TBCTRL, K_TBCNT, K_TBREL, K_GCTRL, K_ISTAT, K_IMASK,
		K_CHCTRL, K_CHVAL
	} ccu_kind_t;
	typedef struct packed {
		ccu_kind_t kind;
		logic [3:0] idx;
	} ccu_dec_t;
endpackage

/* design/ccu_tb_if.sv */
// Link between the unit core and one time base
`timescale 1ns/1ns
`default_nettype none
interface ccu_tb_if;
	logic run;
	logic [2:0] sel;
	logic stag_en;
	logic gp_ovf;
	logic ext_tick;
	logic [15:0] reload;
	logic wr_cnt;
	logic [15:0] wr_data;
	logic [15:0] value;
	logic upd;
	logic ovf;
	modport tb(input run, sel, stag_en, gp_ovf, ext_tick, reload, wr_cnt,
		wr_data, output value, upd, ovf);
	modport core(output run, sel, stag_en, gp_ovf, ext_tick, reload,
		wr_cnt, wr_data, input value, upd, ovf);
endinterface
`default_nettype wire

/* design/ccu_time_base.sv */
// Reloadable 16-bit time base with clock source selection
`timescale 1ns/1ns
`default_nettype none
module ccu_time_base (
	// Clock and reset
	input wire logic clk,
	input wire logic reset,
	// Core link
	ccu_tb_if.tb bus
);
	logic [2:0] pre_q;
	logic [2:0] msk;
	logic step;
	logic [15:0] cnt_q;
	logic upd_q;
	logic ovf_q;

	// ---------------------------------------------------------------
	// Prescaler and source select
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset)
			pre_q <= 3'h0;
		else if (bus.stag_en)
			pre_q <= pre_q + 3'h1;
	end

	always_comb begin
		msk = 3'((4'h1 << bus.sel[1:0]) - 4'h1);
		case (ccu_pkg::ccu_clksel_t'(bus.sel)) // [R3]
			ccu_pkg::CCU_DIV1, ccu_pkg::CCU_DIV2,
			ccu_pkg::CCU_DIV4, ccu_pkg::CCU_DIV8:
				step = bus.stag_en && ((pre_q & msk) == msk);
			ccu_pkg::CCU_GPT: step = bus.gp_ovf;
			ccu_pkg::CCU_EXT: step = bus.ext_tick; // [R4]
			default: step = 1'b0;
		endcase
		step = step && bus.run && !bus.wr_cnt;
	end

	// ---------------------------------------------------------------
	// Counter
	// ---------------------------------------------------------------
	always_ff @(posedge clk) begin
		if (reset)
			cnt_q <= 16'h0000;
		else if (bus.wr_cnt)
			cnt_q <= bus.wr_data;
		else if (step && cnt_q == ccu_pkg::TB_MAX)
			cnt_q <= bus.reload; // [R17]
		else if (step)
			cnt_q <= cnt_q + 16'h0001;
	end

	always_ff @(posedge clk) begin
		if (reset) begin
			upd_q <= 1'b0;
			ovf_q <= 1'b0;
		end else begin
			upd_q <= step;
			ovf_q <= step && cnt_q == ccu_pkg::TB_MAX;
		end
	end

	assign bus.value = cnt_q;
	assign bus.upd = upd_q;
	assign bus.ovf = ovf_q;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	property p_reload;
		@(posedge clk) disable iff (reset)
		ovf_q |-> cnt_q == $past(bus.reload) && upd_q;
	endproperty
	a_reload: assert property (p_reload) // [R17]
		else $error("time base did not reload on overflow");
endmodule
`default_nettype wire

/* design/unused_placeholder_none.sv */
// Intentionally empty design note file
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* testbench/ccu_pin_model.sv */
// Pin-side model for the ten channel pins
`timescale 1ns/1ns
`default_nettype none
module ccu_pin_model (
	// Clock
	input wire logic clk,
	// Pins
	input wire logic [9:0] pin_o,
	input wire logic [9:0] pin_oe,
	output logic [9:0] pin_i
);
	logic [9:0] lvl_q = 10'h000;
	// Driven pins read back their own level
	assign pin_i = (pin_oe & pin_o) | (~pin_oe & lvl_q);
	// Level change, then held three cycles
	task automatic set_pin(input int i, input logic v);
		lvl_q[i] <= v;
		repeat (3) @(posedge clk);
	endtask
endmodule
`default_nettype wire

/* testbench/testbench.sv */
// Self-checking bench for the capture/compare unit
`timescale 1ns/1ns
`default_nettype none
module testbench;
	logic clk = 1'b0;
	logic reset = 1'b1;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0000_0000;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_bready = 1'b0;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_rready = 1'b0;
	logic gp_ovf = 1'b0;
	logic ext_cnt = 1'b0;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
	logic s_axi_rvalid, irq;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [31:0] s_axi_rdata;
	logic [9:0] cc_pin_i, cc_pin_o, cc_pin_oe;
	logic [33:0] rq[$];
	logic [33:0] wq[$];
	logic [15:0] v;
	int err_count = 0;
	int samples_checked = 0;
	always #2 clk = ~clk;
	ccu_capture_compare_unit uut (.clk(clk), .reset(reset),
		.s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(4'hf), .s_axi_wvalid(s_axi_wvalid),
		.s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
		.s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .cc_pin_i(cc_pin_i),
		.cc_pin_o(cc_pin_o), .cc_pin_oe(cc_pin_oe), .ext_count_i(ext_cnt),
		.gp_timer_ovf(gp_ovf), .irq(irq));
	ccu_pin_model pins (.clk(clk), .pin_o(cc_pin_o), .pin_oe(cc_pin_oe),
		.pin_i(cc_pin_i));
	// -----------------------------------------------------------------
	// Checking
	// -----------------------------------------------------------------
	task automatic cmp(input logic [33:0] got, input logic [33:0] exp);
		samples_checked++;
		if (got !== exp) begin
			err_count++;
			$display("mismatch at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic chk(input logic got, input logic exp);
		cmp({33'h0_0000_0000, got}, {33'h0_0000_0000, exp});
	endtask
	always @(posedge clk) begin
		if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1) begin
			if (rq.size() > 0)
				cmp({s_axi_rresp, s_axi_rdata}, rq.pop_front());
		end
		if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1) begin
			if (wq.size() > 0)
				cmp({32'h0000_0000, s_axi_bresp}, wq.pop_front());
		end
	end
	// -----------------------------------------------------------------
	// Bus tasks
	// -----------------------------------------------------------------
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		wq.push_back({32'h0000_0000, r});
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do @(posedge clk); while (s_axi_awready !== 1'b1);
		s_axi_awvalid <= 1'b0;
		s_axi_wvalid <= 1'b0;
		do @(posedge clk); while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r);
		rq.push_back({r, d});
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do @(posedge clk); while (s_axi_arready !== 1'b1);
		s_axi_arvalid <= 1'b0;
		do @(posedge clk); while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
	endtask
	// Capture on tb b, stopped at a random count
	task automatic capture(input logic [31:0] ctl, input logic lvl);
		v = 16'($urandom);
		wr(8'h14, {16'h0000, v}, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_CTRL + 8'h08, ctl, ccu_pkg::RESP_OKAY);
		pins.set_pin(2, lvl);
		repeat (8) @(posedge clk);
		rd(ccu_pkg::A_CH_VAL + 8'h08, {16'h0000, v}, 2'h0);
		chk(irq, 1'b1);
		wr(ccu_pkg::A_ISTAT, 32'h0000_0004, ccu_pkg::RESP_OKAY);
		chk(irq, 1'b0);
	endtask
	// Run tb a from 16'hfff0 for a fixed span, then stop it
	task automatic run_a;
		wr(ccu_pkg::A_TB_COUNT, 32'h0000_fff0, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_TB_CTRL, 32'h0000_0001, ccu_pkg::RESP_OKAY);
		repeat (40) @(posedge clk);
		wr(ccu_pkg::A_TB_CTRL, 32'h0000_0000, ccu_pkg::RESP_OKAY);
		repeat (4) @(posedge clk);
	endtask
	// -----------------------------------------------------------------
	// Closing
	// -----------------------------------------------------------------
	task automatic stop_test;
		$display("errors %0d, checks %0d", err_count, samples_checked);
		if (err_count == 0 && samples_checked > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	initial begin
		#200000;
		err_count++;
		stop_test;
	end
	// -----------------------------------------------------------------
	// Main sequence
	// -----------------------------------------------------------------
	initial begin
		void'($urandom(32'hfe44_4025));
		repeat (4) @(posedge clk);
		reset <= 1'b0;
		@(posedge clk);
		rd(ccu_pkg::A_TB_CTRL, 32'h0000_0000, ccu_pkg::RESP_OKAY);
		rd(8'hfc, 32'h0000_0000, ccu_pkg::RESP_SLVERR);
		wr(8'hfc, 32'h0000_0001, ccu_pkg::RESP_SLVERR);
		wr(ccu_pkg::A_IMASK, 32'h0000_0004, ccu_pkg::RESP_OKAY);
		capture(32'h0000_0013, 1'b1);
		capture(32'h0000_0023, 1'b0);
		capture(32'h0000_0033, 1'b1);
		// Compare channels on tb a reloading at 16'hfff0
		wr(ccu_pkg::A_ISTAT, 32'h0003_ffff, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_TB_RELOAD, 32'h0000_fff0, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_VAL, 32'h0000_fff8, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_CTRL, 32'h0000_0004, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_VAL + 8'h04, 32'h0000_fff4, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_CTRL + 8'h04, 32'h0000_0006, 2'h0);
		chk(cc_pin_oe[1], 1'b1);
		run_a;
		chk(cc_pin_o[1], 1'b1);
		rd(ccu_pkg::A_ISTAT, 32'h0001_0003, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_ISTAT, 32'h0003_ffff, ccu_pkg::RESP_OKAY);
		rd(ccu_pkg::A_ISTAT, 32'h0000_0000, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_TB_COUNT, 32'h0000_fff7, ccu_pkg::RESP_OKAY);
		rd(ccu_pkg::A_TB_COUNT, 32'h0000_fff7, ccu_pkg::RESP_OKAY);
		// Mode 3, double, mode 2 and single event on tb a
		wr(ccu_pkg::A_CH_CTRL, 32'h0000_000a, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_VAL + 8'h24, 32'h0000_fffc, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_CTRL + 8'h04, 32'h0000_000c, 2'h0);
		wr(ccu_pkg::A_CH_VAL + 8'h0c, 32'h0000_fff6, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_CTRL + 8'h0c, 32'h0000_0008, 2'h0);
		wr(ccu_pkg::A_CH_VAL + 8'h10, 32'h0000_fff6, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_CH_CTRL + 8'h10, 32'h0000_0044, 2'h0);
		run_a;
		chk(cc_pin_o[0], 1'b1);
		chk(cc_pin_o[1], 1'b0);
		rd(ccu_pkg::A_ISTAT, 32'h0001_001b, ccu_pkg::RESP_OKAY);
		rd(ccu_pkg::A_CH_CTRL + 8'h10, 32'h0000_00c4, 2'h0);
		// Staggered stepping
		wr(ccu_pkg::A_GCTRL, 32'h0000_0001, ccu_pkg::RESP_OKAY);
		run_a;
		wr(ccu_pkg::A_GCTRL, 32'h0000_0000, ccu_pkg::RESP_OKAY);
		// External count on tb a, timer overflow count on tb b
		wr(ccu_pkg::A_TB_COUNT, 32'h0000_0000, ccu_pkg::RESP_OKAY);
		wr(ccu_pkg::A_TB_CTRL, 32'h0000_000b, ccu_pkg::RESP_OKAY);
		wr(8'h10, 32'h0000_0009, ccu_pkg::RESP_OKAY);
		repeat (3) begin
			ext_cnt <= 1'b1;
			gp_ovf <= 1'b1;
			@(posedge clk);
			gp_ovf <= 1'b0;
			repeat (4) @(posedge clk);
			ext_cnt <= 1'b0;
			repeat (4) @(posedge clk);
		end
		rd(ccu_pkg::A_TB_COUNT, 32'h0000_0003, ccu_pkg::RESP_OKAY);
		rd(8'h14, {16'h0000, 16'(v + 16'h0003)}, 2'h0);
		repeat (4) @(posedge clk);
		stop_test;
	end
endmodule
`default_nettype wire
